// >>> hdl/pic_ctl.sv
// two-level prioritized interrupt controller with an AXI4-Lite register slave
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`include "pic_ctl_regs.svh"
module pic_ctl
   import pic_ctl_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic aclk, // core clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic clk_en, // freezes all state while low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [2:0] core_event, // events: timer, line zero, change
   input wire logic [7:0] group2_event, // peripheral events, group 2
   input wire logic vector_taken, // core took the offered vector
   input wire logic [15:0] return_address, // pc saved at the accept
   input wire logic return_from_handler, // core executes the return
   output logic vector_valid, // vector request to core
   output logic [15:0] vector_address, // vector target
   output logic vector_high, // request is high priority
   output logic irq // unmasked event status
);
   // core byte: enables 5..3, flags 2..0; group2 bytes are peripherals
   logic [7:0] core_interrupt_control;
   logic [7:0] group2_source_flags;
   logic [7:0] group2_source_enable;
   logic [7:0] group2_source_priority;
   logic priority_scheme_enable;
   logic [1:0] evt_status;
   logic [1:0] evt_mask;
   logic [15:0] saved_return;
   pic_level_type level;
   pic_vector_type offer;
   logic aw_held, w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                        input logic en);
      merge = en ? d : old;
   endfunction

   wire global_or_high_level_enable = core_interrupt_control[`PIC_BIT_GHIGH];
   wire peripheral_or_low_level_enable = core_interrupt_control[`PIC_BIT_GLOW];

   // per-source pending: flag and its own enable
   wire [2:0] core_pend = core_interrupt_control[2:0] & core_interrupt_control[5:3];
   wire [7:0] g2_pend = group2_source_flags & group2_source_enable;
   // selectors only count with the scheme on; line zero has none
   wire [7:0] g2_prio = priority_scheme_enable ? group2_source_priority : 8'hff;
   wire [7:0] g2_high = g2_pend & g2_prio;
   wire [7:0] g2_low = g2_pend & ~g2_prio;
   // core sources, line zero included, are all treated as high priority
   wire core_any = |core_pend;

   // compat: global gates all, peripheral enable gates peripherals
   wire compat_req = global_or_high_level_enable &
                     (core_any | (peripheral_or_low_level_enable & (|g2_pend)));
   wire high_req = global_or_high_level_enable & (core_any | (|g2_high));
   wire low_req = global_or_high_level_enable & peripheral_or_low_level_enable &
                  (|g2_low);
   wire in_high = (level == PIC_IN_HIGH) || (level == PIC_IN_LOW_HIGH);
   // high may enter while low runs; low waits out any high handler
   wire take_high = priority_scheme_enable ? (high_req && !in_high)
                                           : (compat_req && level == PIC_IDLE);
   wire take_low = priority_scheme_enable && low_req && level == PIC_IDLE;
   wire accept = !offer.valid && (take_high || take_low);

   // bus decode
   wire do_write = aw_held && w_held && !s_axi_bvalid;
   wire do_read = s_axi_arvalid && s_axi_arready;
   wire wr_core = do_write && aw_addr == `PIC_OFS_CORE_CTL && w_strb[0];
   wire wr_flags = do_write && aw_addr == `PIC_OFS_G2_FLAGS && w_strb[0];
   wire wr_en = do_write && aw_addr == `PIC_OFS_G2_ENABLE && w_strb[0];
   wire wr_prio = do_write && aw_addr == `PIC_OFS_G2_PRIO && w_strb[0];
   wire wr_rst = do_write && aw_addr == `PIC_OFS_RESET_CTL && w_strb[0];
   wire wr_stat = do_write && aw_addr == `PIC_OFS_EVT_STATUS && w_strb[0];
   wire wr_mask = do_write && aw_addr == `PIC_OFS_EVT_MASK && w_strb[0];
   wire wr_hit = aw_addr == `PIC_OFS_CORE_CTL || aw_addr == `PIC_OFS_G2_FLAGS ||
                 aw_addr == `PIC_OFS_G2_ENABLE || aw_addr == `PIC_OFS_G2_PRIO ||
                 aw_addr == `PIC_OFS_RESET_CTL || aw_addr == `PIC_OFS_EVT_STATUS ||
                 aw_addr == `PIC_OFS_EVT_MASK;
   logic [7:0] rd_byte;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `PIC_OFS_CORE_CTL: rd_byte = core_interrupt_control;
         `PIC_OFS_G2_FLAGS: rd_byte = group2_source_flags;
         `PIC_OFS_G2_ENABLE: rd_byte = group2_source_enable;
         `PIC_OFS_G2_PRIO: rd_byte = group2_source_priority;
         `PIC_OFS_RESET_CTL: rd_byte = {priority_scheme_enable, 7'h00};
         `PIC_OFS_EVT_STATUS: rd_byte = {6'h00, evt_status};
         `PIC_OFS_EVT_MASK: rd_byte = {6'h00, evt_mask};
         `PIC_OFS_VECTOR: rd_byte = {1'b0, level == PIC_IN_LOW_HIGH, in_high,
                                     level != PIC_IDLE, 4'h0};
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // enable bits: software write, cleared on accept, restored on return
   wire ret_low = return_from_handler && level == PIC_IN_LOW;
   wire ret_high = return_from_handler && in_high;
   logic next_ghigh, next_glow;
   always_comb begin
      next_ghigh = wr_core ? w_data[`PIC_BIT_GHIGH] : global_or_high_level_enable;
      next_glow = wr_core ? w_data[`PIC_BIT_GLOW] : peripheral_or_low_level_enable;
      if (accept && (take_high || !priority_scheme_enable))
         next_ghigh = 1'b0;
      else if (accept)
         next_glow = 1'b0;
      // the high return restores the high enable only; low stays as left
      if (ret_high || (return_from_handler && !priority_scheme_enable))
         next_ghigh = 1'b1;
      else if (ret_low)
         next_glow = 1'b1;
   end
   // flags: event set wins over a software clear
   // a function result cannot be part-selected, so name the merged byte
   wire [7:0] core_written = merge(core_interrupt_control, w_data[7:0], wr_core);
   wire [2:0] next_core_flags = core_written[2:0] | core_event;
   wire [7:0] next_g2_flags = merge(group2_source_flags, w_data[7:0], wr_flags) |
                              group2_event;

   logic [1:0] next_level;
   always_comb begin
      case (level)
         PIC_IDLE: next_level = accept ? (take_high ? 2'(PIC_IN_HIGH) : 2'(PIC_IN_LOW))
                                       : 2'(PIC_IDLE);
         PIC_IN_LOW: next_level = accept ? 2'(PIC_IN_LOW_HIGH)
                                 : (ret_low ? 2'(PIC_IDLE) : 2'(PIC_IN_LOW));
         PIC_IN_HIGH: next_level = return_from_handler ? 2'(PIC_IDLE) : 2'(PIC_IN_HIGH);
         PIC_IN_LOW_HIGH: next_level = return_from_handler ? 2'(PIC_IN_LOW)
                                                           : 2'(PIC_IN_LOW_HIGH);
         default: next_level = 2'(PIC_IDLE);
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core_interrupt_control <= `PIC_RST_CORE_CTL;
         group2_source_flags <= `PIC_RST_G2;
         group2_source_enable <= `PIC_RST_G2;
         group2_source_priority <= `PIC_RST_G2_PRIO;
         priority_scheme_enable <= 1'b0;
         level <= PIC_IDLE;
      end else if (clk_en) begin
         core_interrupt_control <= {next_ghigh, next_glow,
                                    core_written[5:3],
                                    next_core_flags};
         group2_source_flags <= next_g2_flags;
         group2_source_enable <= merge(group2_source_enable, w_data[7:0], wr_en);
         group2_source_priority <= merge(group2_source_priority, w_data[7:0], wr_prio);
         if (wr_rst)
            priority_scheme_enable <= w_data[`PIC_BIT_PRIO_EN];
         level <= pic_level_type'(next_level);
      end
   end

   // vector offer to the core, held until taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         offer <= '0;
         saved_return <= 16'h0000;
      end else if (clk_en) begin
         if (accept) begin
            offer.valid <= 1'b1;
            offer.high <= take_high;
            offer.address <= take_high ? `PIC_VEC_HIGH : `PIC_VEC_LOW;
            saved_return <= return_address;
         end else if (vector_taken) begin
            offer.valid <= 1'b0;
         end
      end
   end
   assign vector_valid = offer.valid;
   assign vector_address = offer.address;
   assign vector_high = offer.high;

   // status: bit 0 high accept, bit 1 low accept; set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         evt_status <= 2'b00;
         evt_mask <= 2'b00;
         irq <= 1'b0;
      end else if (clk_en) begin
         evt_status <= (evt_status & ~(wr_stat ? w_data[1:0] : 2'b00)) |
                       {accept && !take_high, accept && take_high};
         if (wr_mask)
            evt_mask <= w_data[1:0];
         irq <= |(evt_status & evt_mask);
      end
   end

   // axi4-lite slave: address and data accepted in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h00000000;
      end else if (clk_en) begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h000000, rd_byte};
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// >>> hdl/pic_ctl_pkg.sv
// types shared by the interrupt controller
package pic_ctl_pkg;
   typedef enum logic [1:0] {
      PIC_IDLE,
      PIC_IN_LOW,
      PIC_IN_HIGH,
      PIC_IN_LOW_HIGH
   } pic_level_type;
   typedef struct packed {
      logic valid;
      logic [15:0] address;
      logic high;
   } pic_vector_type;
endpackage

// >>> hdl/pic_ctl_regs.svh
// register offsets, field positions, reset values and vector constants of the interrupt controller
`ifndef PIC_CTL_REGS_SVH
`define PIC_CTL_REGS_SVH
`define PIC_OFS_CORE_CTL 8'h00
`define PIC_OFS_G2_FLAGS 8'h04
`define PIC_OFS_G2_ENABLE 8'h08
`define PIC_OFS_G2_PRIO 8'h0c
`define PIC_OFS_RESET_CTL 8'h10
`define PIC_OFS_EVT_STATUS 8'h14
`define PIC_OFS_EVT_MASK 8'h18
`define PIC_OFS_VECTOR 8'h1c
`define PIC_BIT_GHIGH 7
`define PIC_BIT_GLOW 6
`define PIC_BIT_TIMER_EN 5
`define PIC_BIT_LINE0_EN 4
`define PIC_BIT_CHANGE_EN 3
`define PIC_BIT_TIMER_FLAG 2
`define PIC_BIT_LINE0_FLAG 1
`define PIC_BIT_CHANGE_FLAG 0
`define PIC_BIT_PRIO_EN 7
`define PIC_RST_CORE_CTL 8'h00
`define PIC_RST_G2 8'h00
`define PIC_RST_G2_PRIO 8'hff
`define PIC_VEC_HIGH 16'h0008
`define PIC_VEC_LOW 16'h0018
`endif

// >>> testbench/pri_core_model.sv
// core sequencer stand-in: takes vector offers and issues returns
module pri_core_model (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low active
   input wire logic vector_valid, // offer from controller
   input wire logic [1:0] delay, // cycles before taking
   input wire logic ret_cmd, // bench asks for a return
   output logic vector_taken, // one-cycle take
   output logic [15:0] return_address, // pseudo program counter
   output logic return_from_handler // return pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vector_taken <= 1'h0;
         wait_cnt <= 2'h0;
         return_address <= 16'h0100;
         return_from_handler <= 1'h0;
      end else begin
         return_address <= return_address + 16'h0002;
         return_from_handler <= ret_cmd;
         // >= so a delay changed mid-wait cannot strand the offer
         if (vector_taken || !vector_valid) begin
            vector_taken <= 1'h0;
            wait_cnt <= 2'h0;
         end else if (wait_cnt >= delay)
            vector_taken <= 1'h1;
         else
            wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule

// >>> testbench/pri_ctl_checker.sv
// port assertions for the interrupt controller
module pri_ctl_checker (
   input wire logic aclk, // clock
   input wire logic aresetn, // reset, low active
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_bready, // b ready
   input wire logic [1:0] s_axi_bresp, // b response
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic s_axi_rvalid, // r valid
   input wire logic [31:0] s_axi_rdata, // r data
   input wire logic vector_valid, // vector offer
   input wire logic vector_taken, // core took it
   input wire logic [15:0] vector_address, // target
   input wire logic vector_high // level
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence offer_s;
      vector_valid && !vector_taken;
   endsequence
   sequence took_s;
      vector_valid && vector_taken;
   endsequence
   vec_hold_a: assert property (offer_s |=> vector_valid && $stable(vector_address))
      else $error("vector offer dropped or changed");
   level_hold_a: assert property (offer_s |=> $stable(vector_high))
      else $error("vector level changed while offered");
   vec_addr_a: assert property (vector_valid |->
      vector_address == (vector_high ? 16'h0008 : 16'h0018)) else $error("wrong vector target");
   vec_once_a: assert property (took_s |=> !vector_valid)
      else $error("offer stayed after take");
   wr_resp_a: assert property (s_axi_awready && s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response late");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
   rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read data late");
   rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("write address taken twice");
endmodule
bind pic_ctl pri_ctl_checker chk_inst (.*);

// >>> testbench/prioritized_interrupt_control_test.sv
// self-checking bench for the interrupt controller
module prioritized_interrupt_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1, ret_cmd = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, group2_event = 8'h00;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, delay = 2'h0;
   logic [2:0] core_event = 3'h0;
   logic vector_taken, return_from_handler, vector_valid, vector_high, irq;
   logic [15:0] return_address, vector_address;
   logic [7:0] src;
   int num_errors = 0, compares = 0, seed = 32'h3e41;
   pic_ctl pic_ctl_inst (.*);
   pri_core_model pri_core_model_inst (.*);
   initial forever #50 aclk = ~aclk;
   task automatic end_of_test;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic tmo(input int n);
      if (n >= 40) begin
         num_errors++;
         end_of_test;
      end
   endtask
   // behaviour model of the vector target
   function automatic logic [31:0] exp_vec(input bit prio, input bit hi);
      return (prio && !hi) ? 32'h0018 : 32'h0008;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         n++;
      end while (!s_axi_bvalid && n < 40);
      s_axi_bready <= 1'h0;
      tmo(n);
      chk("bresp", 32'h0, {30'h0, s_axi_bresp});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         n++;
      end while (!s_axi_rvalid && n < 40);
      s_axi_rready <= 1'h0;
      tmo(n);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask
   task automatic ev(input logic [2:0] c, input logic [7:0] g);
      @(posedge aclk);
      core_event <= c;
      group2_event <= g;
      @(posedge aclk);
      core_event <= 3'h0;
      group2_event <= 8'h00;
   endtask
   task automatic vec(input logic [31:0] e);
      int n;
      n = 0;
      delay <= 2'($random(seed));
      do begin
         @(posedge aclk);
         n++;
      end while (!(vector_valid && vector_taken) && n < 40);
      tmo(n);
      chk("vector_address", e, {16'h0000, vector_address});
   endtask
   task automatic quiet;
      repeat (6) @(posedge aclk);
      chk("vector_valid", 32'h0, {31'h0, vector_valid});
   endtask
   task automatic ret;
      @(posedge aclk);
      ret_cmd <= 1'h1;
      @(posedge aclk);
      ret_cmd <= 1'h0;
      repeat (3) @(posedge aclk);
   endtask
   initial begin
      src = 8'h01 << ($unsigned($random(seed)) % 8);
      repeat (5) @(posedge aclk);
      aresetn <= 1'h1;
      rd(8'h00, 32'h00, 2'h0);
      rd(8'h0c, 32'hff, 2'h0);
      rd(8'h10, 32'h00, 2'h0);
      rd(8'h24, 32'h00, 2'h2);
      wr(8'h08, {24'h0, src});
      wr(8'h00, 32'h80);
      ev(3'h0, src);
      quiet();
      rd(8'h04, {24'h0, src}, 2'h0);
      wr(8'h00, 32'hc0);
      vec(exp_vec(0, 0));
      rd(8'h00, 32'h40, 2'h0);
      wr(8'h04, 32'h0);
      ret();
      rd(8'h00, 32'hc0, 2'h0);
      wr(8'h00, 32'h40);
      ev(3'h0, src);
      quiet();
      wr(8'h04, 32'h0);
      wr(8'h10, 32'h80);
      wr(8'h0c, {24'h0, ~src});
      wr(8'h00, 32'hd0);
      ev(3'h0, src);
      vec(exp_vec(1, 0));
      rd(8'h00, 32'h90, 2'h0);
      ev(3'h2, 8'h00);
      vec(exp_vec(1, 1));
      // reopen both levels inside the high handler, low still pending
      wr(8'h00, 32'hd0);
      quiet();
      wr(8'h18, 32'h3);
      rd(8'h14, 32'h3, 2'h0);
      chk("irq", 32'h1, {31'h0, irq});
      wr(8'h14, 32'h3);
      wr(8'h04, 32'h0);
      repeat (2) @(posedge aclk);
      chk("irq", 32'h0, {31'h0, irq});
      ret();
      ret();
      // high enable clear holds back a pending low source
      wr(8'h00, 32'h40);
      ev(3'h0, src);
      quiet();
      // the same source moved to high vectors with only the high enable
      wr(8'h0c, 32'hff);
      wr(8'h00, 32'h80);
      vec(exp_vec(1, 1));
      rd(8'h00, 32'h00, 2'h0);
      end_of_test;
   end
endmodule
